// [design/ptc_params.svh]
// offsets, field positions, reset values and widths of the period timer
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define PTC_ADDR_W 4
`define PTC_OFS_CONTROL 4'h0
`define PTC_OFS_PERIOD 4'h1
`define PTC_OFS_COUNT 4'h2
`define PTC_OFS_FLAGS 4'h3

// ****************************************
// control register fields
// ****************************************
`define PTC_CTRL_UNUSED_BIT 7
`define PTC_POST_HI 6
`define PTC_POST_LO 3
`define PTC_RUN_BIT 2
`define PTC_PRE_HI 1
`define PTC_PRE_LO 0
`define PTC_CTRL_MASK 8'h7F

// ****************************************
// flag register fields
// ****************************************
`define PTC_FLAG_BIT 0
`define PTC_IRQ_EN_BIT 1

// ****************************************
// reset values
// ****************************************
`define PTC_RST_CONTROL 8'h00
`define PTC_RST_PERIOD 8'hFF
`define PTC_RST_COUNT 8'h00
`define PTC_RST_FLAGS 2'h0

// ****************************************
// prescaler terminal counts
// ****************************************
`define PTC_PRE_TERM_1 6'h00
`define PTC_PRE_TERM_4 6'h03
`define PTC_PRE_TERM_16 6'h0F
`define PTC_PRE_TERM_64 6'h3F

`endif

// [design/ptc_pkg.sv]
// types and shared decoding of the period timer
`include "ptc_params.svh"

package ptc_pkg;

    typedef logic [7:0] ptc_byte_type;
    typedef logic [5:0] ptc_pre_cnt_type;
    typedef logic [1:0] ptc_pre_sel_type;
    typedef logic [3:0] ptc_post_type;

    // terminal count of the input prescaler for a select code
    function automatic ptc_pre_cnt_type ptc_pre_term(input ptc_pre_sel_type sel);
        case (sel)
            2'h0: ptc_pre_term = `PTC_PRE_TERM_1;
            2'h1: ptc_pre_term = `PTC_PRE_TERM_4;
            2'h2: ptc_pre_term = `PTC_PRE_TERM_16;
            default: ptc_pre_term = `PTC_PRE_TERM_64;
        endcase
    endfunction : ptc_pre_term

endpackage : ptc_pkg

// [design/ptc_prescaler.sv]
// input prescaler of the period timer
`timescale 1ns/1ps

module ptc_prescaler
    import ptc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic clear,
    input wire ptc_pre_sel_type sel,
    output logic tick
);

    ptc_pre_cnt_type cnt;
    ptc_pre_cnt_type next_cnt;
    ptc_pre_cnt_type term;

    // ****************************************
    // divider
    // ****************************************
    // greater-or-equal guards against a select that shrinks mid-count
    assign term = ptc_pre_term(sel);
    assign tick = run && !clear && (cnt >= term);

    // divide by 1, 4, 16 or 64
    always_comb begin
        next_cnt = cnt;
        if (!run || clear || tick) begin
            next_cnt = 6'h00;
        end else begin
            next_cnt = cnt + 6'h01;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 6'h00;
        end else begin
            cnt <= next_cnt;
        end
    end

endmodule : ptc_prescaler

// [design/ptc_timer.sv]
// period timer: control register, count, period match and postscaler
// Functional notes
// - control bits 6 to 3 choose an output postscale of code plus one, 1:1 to 1:16.
// - control bit 2 at one runs the timer and at zero stops it.
// - control bits 1 to 0 choose an input prescale of 1, 4, 16 or 64.
// - control bit 7 is absent, reads zero and ignores writes.
// - all other control bits are read/write and clear to zero on every reset.
// - a separate software period register bounds each counting period.
// - the running count is an 8-bit register software can read and write.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module ptc_timer
    import ptc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [`PTC_ADDR_W-1:0] reg_addr,
    input wire ptc_byte_type reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output ptc_byte_type reg_rdata,
    output logic period_match_flag,
    output logic period_match_irq_enable
);

    // ****************************************
    // state
    // ****************************************
    ptc_byte_type control;
    ptc_byte_type next_control;
    ptc_byte_type period;
    ptc_byte_type next_period;
    ptc_byte_type count;
    ptc_byte_type next_count;
    ptc_post_type post_cnt;
    ptc_post_type next_post_cnt;
    logic flag;
    logic next_flag;
    logic irq_en;
    logic next_irq_en;
    ptc_byte_type next_rdata;

    logic wr_ctrl;
    logic wr_period;
    logic wr_count;
    logic wr_flags;
    logic run;
    logic tick;
    logic match;
    logic post_done;
    ptc_post_type post_sel;

    assign wr_ctrl = reg_wr && (reg_addr == `PTC_OFS_CONTROL);
    assign wr_period = reg_wr && (reg_addr == `PTC_OFS_PERIOD);
    assign wr_count = reg_wr && (reg_addr == `PTC_OFS_COUNT);
    assign wr_flags = reg_wr && (reg_addr == `PTC_OFS_FLAGS);
    assign run = control[`PTC_RUN_BIT];
    assign post_sel = control[`PTC_POST_HI:`PTC_POST_LO];
    assign match = tick && (count == period);
    assign post_done = match && (post_cnt == post_sel);

    // ****************************************
    // prescaler
    // ****************************************
    // writes to count or control restart the prescaler, as a fresh period should
    ptc_prescaler u_prescaler (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(run),
        .clear(wr_ctrl || wr_count),
        .sel(control[`PTC_PRE_HI:`PTC_PRE_LO]),
        .tick(tick)
    );

    // ****************************************
    // registers and counting
    // ****************************************
    always_comb begin
        next_control = control;
        next_period = period;
        next_count = count;
        next_post_cnt = post_cnt;
        next_flag = flag;
        next_irq_en = irq_en;
        if (wr_ctrl) begin
            next_control = reg_wdata & `PTC_CTRL_MASK;
        end
        if (wr_period) begin
            next_period = reg_wdata;
        end
        if (match) begin
            next_count = 8'h00;
            next_post_cnt = post_done ? 4'h0 : post_cnt + 4'h1;
        end else if (tick) begin
            next_count = count + 8'h01;
        end
        if (wr_count) begin
            next_count = reg_wdata;
            next_post_cnt = 4'h0;
        end
        if (wr_flags) begin
            next_flag = reg_wdata[`PTC_FLAG_BIT];
            next_irq_en = reg_wdata[`PTC_IRQ_EN_BIT];
        end
        // set beats a same-cycle clear
        if (post_done) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            control <= `PTC_RST_CONTROL;
            period <= `PTC_RST_PERIOD;
            count <= `PTC_RST_COUNT;
            post_cnt <= 4'h0;
            {irq_en, flag} <= `PTC_RST_FLAGS;
        end else begin
            control <= next_control;
            period <= next_period;
            count <= next_count;
            post_cnt <= next_post_cnt;
            flag <= next_flag;
            irq_en <= next_irq_en;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    // data stand one cycle only; unmapped offsets read zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `PTC_OFS_CONTROL: next_rdata = control;
                `PTC_OFS_PERIOD: next_rdata = period;
                `PTC_OFS_COUNT: next_rdata = count;
                `PTC_OFS_FLAGS: next_rdata = {6'h00, irq_en, flag};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    assign period_match_flag = flag;
    assign period_match_irq_enable = irq_en;

    // ****************************************
    // assertions
    // ****************************************
    property p_post_flag;
        @(posedge mclk) disable iff (sys_rst)
        post_done |=> period_match_flag;
    endproperty
    a_post_flag: assert property (p_post_flag) else $error("flag missed on postscale");

    property p_post_early;
        @(posedge mclk) disable iff (sys_rst)
        (match && (post_cnt != post_sel) && !period_match_flag && !wr_flags)
            |=> !period_match_flag;
    endproperty
    a_post_early: assert property (p_post_early) else $error("flag set early");

    property p_stop_hold;
        @(posedge mclk) disable iff (sys_rst)
        (!run && !wr_count) |=> $stable(count);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped");

    property p_pre4;
        @(posedge mclk) disable iff (sys_rst)
        (tick && control[`PTC_PRE_HI:`PTC_PRE_LO] == 2'h1)
            |=> (!tick || control[`PTC_PRE_HI:`PTC_PRE_LO] != 2'h1) [*3];
    endproperty
    a_pre4: assert property (p_pre4) else $error("prescale 4 spacing wrong");

    property p_bit7_zero;
        @(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr == `PTC_OFS_CONTROL) |=> (reg_rdata[`PTC_CTRL_UNUSED_BIT] == 1'b0);
    endproperty
    a_bit7_zero: assert property (p_bit7_zero) else $error("control bit 7 not zero");

    property p_ctrl_rw;
        @(posedge mclk) disable iff (sys_rst)
        (wr_ctrl ##1 (reg_rd && reg_addr == `PTC_OFS_CONTROL))
            |=> (reg_rdata == ($past(reg_wdata, 2) & `PTC_CTRL_MASK));
    endproperty
    a_ctrl_rw: assert property (p_ctrl_rw) else $error("control readback wrong");

    property p_period_wr;
        @(posedge mclk) disable iff (sys_rst)
        wr_period |=> (period == $past(reg_wdata));
    endproperty
    a_period_wr: assert property (p_period_wr) else $error("period not stored");

    property p_count_wr;
        @(posedge mclk) disable iff (sys_rst)
        wr_count |=> (count == $past(reg_wdata));
    endproperty
    a_count_wr: assert property (p_count_wr) else $error("count not stored");

    property p_count_inc;
        @(posedge mclk) disable iff (sys_rst)
        (tick && !match && !wr_count) |=> (count == $past(count) + 8'h01);
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("count did not step");

    property p_match_clr;
        @(posedge mclk) disable iff (sys_rst)
        (match && !wr_count) |=> (count == 8'h00);
    endproperty
    a_match_clr: assert property (p_match_clr) else $error("count kept on match");

    c_match: cover property (@(posedge mclk) disable iff (sys_rst) match);
    c_flag: cover property (@(posedge mclk) disable iff (sys_rst) post_done && post_sel == 4'hF);
    c_set_clr: cover property (@(posedge mclk) disable iff (sys_rst) post_done && wr_flags);
    c_pre64: cover property (@(posedge mclk) disable iff (sys_rst)
        tick && control[`PTC_PRE_HI:`PTC_PRE_LO] == 2'h3);

endmodule : ptc_timer

// [sim/tb_top.sv]
// self-checking bench for the period timer
`timescale 1ns/1ps
`include "ptc_params.svh"

module tb_top
    import ptc_pkg::*;
;
    logic mclk;
    logic sys_rst;
    logic [`PTC_ADDR_W-1:0] reg_addr;
    ptc_byte_type reg_wdata;
    logic reg_wr;
    logic reg_rd;
    ptc_byte_type reg_rdata;
    logic period_match_flag;
    logic period_match_irq_enable;
    int err_count;
    int checks;

    ptc_timer dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .period_match_flag(period_match_flag),
        .period_match_irq_enable(period_match_irq_enable));

    // ****************************************
    // clock, reset, watchdog
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        #(40 * 20000);
        err_count++;
        finish_test();
    end

    // ****************************************
    // bus tasks and comparison
    // ****************************************
    task automatic check(input ptc_byte_type got, input ptc_byte_type exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] addr, input ptc_byte_type data);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] addr, output ptc_byte_type data);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask : rd

    task automatic rd_chk(input logic [3:0] addr, input ptc_byte_type exp);
        ptc_byte_type v;
        rd(addr, v);
        check(v, exp);
    endtask : rd_chk

    // ****************************************
    // scenarios
    // ****************************************
    task automatic reset_values();
        rd_chk(`PTC_OFS_CONTROL, 8'h00);
        rd_chk(`PTC_OFS_PERIOD, 8'hFF);
        rd_chk(`PTC_OFS_COUNT, 8'h00);
        rd_chk(`PTC_OFS_FLAGS, 8'h00);
        check({6'h00, period_match_flag, period_match_irq_enable}, 8'h00);
    endtask : reset_values

    task automatic reg_access();
        // bit 7 absent: a write of FB (all ones but the run bit) reads back without it
        wr(`PTC_OFS_CONTROL, 8'hFB);
        rd_chk(`PTC_OFS_CONTROL, 8'h7B);
        wr(`PTC_OFS_CONTROL, 8'h80);
        rd_chk(`PTC_OFS_CONTROL, 8'h00);
        wr(`PTC_OFS_PERIOD, 8'h5A);
        rd_chk(`PTC_OFS_PERIOD, 8'h5A);
        wr(`PTC_OFS_COUNT, 8'hA5);
        rd_chk(`PTC_OFS_COUNT, 8'hA5);
        wr(4'h9, 8'h33);
        rd_chk(4'h9, 8'h00);
        rd_chk(`PTC_OFS_PERIOD, 8'h5A);
        wr(`PTC_OFS_FLAGS, 8'h02);
        // let the write land before looking at the pin
        #1;
        check({7'h00, period_match_irq_enable}, 8'h01);
        rd_chk(`PTC_OFS_FLAGS, 8'h02);
        wr(`PTC_OFS_FLAGS, 8'h00);
    endtask : reg_access

    // time from run to flag: (period+1) ticks per match, div clocks per tick, post+1 matches
    task automatic timed_run(input logic [1:0] pre, input logic [3:0] post,
        input ptc_byte_type per);
        int div;
        int exp;
        int n;
        div = (pre == 2'h0) ? 1 : (pre == 2'h1) ? 4 : (pre == 2'h2) ? 16 : 64;
        exp = (int'(per) + 1) * div * (int'(post) + 1);
        wr(`PTC_OFS_CONTROL, 8'h00);
        wr(`PTC_OFS_COUNT, 8'h00);
        wr(`PTC_OFS_FLAGS, 8'h00);
        wr(`PTC_OFS_PERIOD, per);
        wr(`PTC_OFS_CONTROL, {1'b0, post, 1'b1, pre});
        n = 0;
        while (period_match_flag !== 1'b1 && n < exp + 10) begin
            @(posedge mclk);
            #1;
            n++;
        end
        checks++;
        // first tick one prescale period after the run write, flag on the last match
        if (n != exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, n, exp);
        end
    endtask : timed_run

    task automatic stop_holds();
        ptc_byte_type a;
        ptc_byte_type b;
        timed_run(2'h0, 4'h0, 8'hFF);
        rd(`PTC_OFS_COUNT, a);
        rd(`PTC_OFS_COUNT, b);
        check({7'h00, a !== b}, 8'h01);
        wr(`PTC_OFS_CONTROL, 8'h00);
        rd(`PTC_OFS_COUNT, a);
        repeat (6) @(posedge mclk);
        rd(`PTC_OFS_COUNT, b);
        check(b, a);
        rd_chk(`PTC_OFS_FLAGS, 8'h01);
    endtask : stop_holds

    task automatic mid_reset();
        wr(`PTC_OFS_PERIOD, 8'h11);
        wr(`PTC_OFS_COUNT, 8'h22);
        wr(`PTC_OFS_FLAGS, 8'h03);
        wr(`PTC_OFS_CONTROL, 8'h7F);
        rd_chk(`PTC_OFS_CONTROL, 8'h7F);
        rd_chk(`PTC_OFS_FLAGS, 8'h03);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        reset_values();
    endtask : mid_reset

    task automatic finish_test();
        $display("mismatches %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        err_count = 0;
        checks = 0;
        sys_rst = 1'b1;
        reg_addr = '0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        reset_values();
        reg_access();
        for (int p = 0; p < 4; p++) begin
            timed_run(p[1:0], 4'h0, 8'h02);
        end
        timed_run(2'h0, 4'h1, 8'h00);
        timed_run(2'h0, 4'h7, 8'h00);
        timed_run(2'h0, 4'hF, 8'h00);
        timed_run(2'h1, 4'h2, 8'h04);
        stop_holds();
        mid_reset();
        finish_test();
    end
endmodule : tb_top
